/* File: logic/far_slave.sv */
// Far party: a simple two-wire slave that acknowledges its own address and every byte it receives.
// Assumes the bus interface carrier and a clock far faster than SCL.
`timescale 1ns/1ns
`default_nettype none
module far_slave #(
  parameter logic [6:0] MY_ADDR = two_wire_pkg::FAR_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  two_wire_if.far bus,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte,
  output logic rxStrobe,
  output logic addressed
);
  import two_wire_pkg::*;
  logic sclMeta_r, sclSync_r, sclLast_r, sdaMeta_r, sdaSync_r, sdaLast_r;
  logic sclRise, sclFall, startSeen, stopSeen;
  far_state_t state_r, state_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shift_r, shift_nxt, rxByte_r, rxByte_nxt;
  logic first_r, first_nxt, isTx_r, isTx_nxt, sel_r, sel_nxt, sdaOeN_r, sdaOeN_nxt, strobe_r, strobe_nxt;

  // Two-stage synchronisers plus edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {sclMeta_r, sclSync_r, sclLast_r, sdaMeta_r, sdaSync_r, sdaLast_r} <= 6'h3F;
    end else begin
      {sclMeta_r, sclSync_r, sclLast_r} <= {bus.scl, sclMeta_r, sclSync_r};
      {sdaMeta_r, sdaSync_r, sdaLast_r} <= {bus.sda, sdaMeta_r, sdaSync_r};
    end
  end
  assign sclRise = sclSync_r & ~sclLast_r;
  assign sclFall = ~sclSync_r & sclLast_r;
  assign startSeen = sclSync_r & sclLast_r & sdaLast_r & ~sdaSync_r;
  assign stopSeen = sclSync_r & sclLast_r & ~sdaLast_r & sdaSync_r;

  // Byte engine: address, data, acknowledge
  always_comb begin
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    rxByte_nxt = rxByte_r;
    first_nxt = first_r;
    isTx_nxt = isTx_r;
    sel_nxt = sel_r;
    sdaOeN_nxt = sdaOeN_r;
    strobe_nxt = 1'b0;
    if (startSeen) begin
      state_nxt = F_BIT;
      bitCnt_nxt = 4'hF; // Start's own clock fall wraps this to bit 0
      first_nxt = 1'b1;
      isTx_nxt = 1'b0;
      sel_nxt = 1'b0;
      sdaOeN_nxt = 1'b1;
    end else if (stopSeen) begin
      state_nxt = F_IDLE;
      sel_nxt = 1'b0;
      sdaOeN_nxt = 1'b1;
    end else if (state_r == F_BIT) begin
      if (sclRise && bitCnt_r <= LAST_DATA_BIT) begin
        shift_nxt = {shift_r[6:0], sdaSync_r};
      end else if (sclRise && isTx_r && sdaSync_r) begin
        state_nxt = F_IDLE;
      end else if (sclFall) begin
        if (bitCnt_r == LAST_DATA_BIT) begin
          bitCnt_nxt = ACK_BIT;
          if (first_r) begin
            if (shift_r[7:1] == MY_ADDR) begin
              sdaOeN_nxt = 1'b0;
              sel_nxt = 1'b1;
            end else begin
              state_nxt = F_IDLE;
            end
          end else if (!isTx_r) begin
            sdaOeN_nxt = 1'b0;
            rxByte_nxt = shift_r;
            strobe_nxt = 1'b1;
          end else begin
            sdaOeN_nxt = 1'b1;
          end
        end else if (bitCnt_r == ACK_BIT) begin
          bitCnt_nxt = 4'h0;
          if (first_r) begin
            isTx_nxt = shift_r[0];
            first_nxt = 1'b0;
          end
          if (first_r ? shift_r[0] : isTx_r) begin
            shift_nxt = txByte;
            sdaOeN_nxt = txByte[7];
          end else begin
            sdaOeN_nxt = 1'b1;
          end
        end else begin
          bitCnt_nxt = bitCnt_r + 4'h1;
          sdaOeN_nxt = isTx_r ? shift_r[7] : 1'b1;
        end
      end
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= F_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      rxByte_r <= 8'h00;
      first_r <= 1'b0;
      isTx_r <= 1'b0;
      sel_r <= 1'b0;
      sdaOeN_r <= 1'b1;
      strobe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      rxByte_r <= rxByte_nxt;
      first_r <= first_nxt;
      isTx_r <= isTx_nxt;
      sel_r <= sel_nxt;
      sdaOeN_r <= sdaOeN_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  assign rxByte = rxByte_r;
  assign rxStrobe = strobe_r;
  assign addressed = sel_r;
  assign bus.farSclOut = 1'b0;
  assign bus.farSclOeN = 1'b1;
  assign bus.farSdaOut = 1'b0;
  assign bus.farSdaOeN = sdaOeN_r;
endmodule : far_slave
`default_nettype wire

/* File: logic/two_wire_if.sv */
// Open-drain two-wire bus joining the port and the far party.
// Assumes each end drives only low; enables are active low.
`timescale 1ns/1ns
`default_nettype none
interface two_wire_if;
  logic devSclOut;
  logic devSclOeN;
  logic devSdaOut;
  logic devSdaOeN;
  logic farSclOut;
  logic farSclOeN;
  logic farSdaOut;
  logic farSdaOeN;
  logic scl;
  logic sda;
  // Wired-AND of both ends with pull-up
  assign scl = (devSclOeN | devSclOut) & (farSclOeN | farSclOut);
  assign sda = (devSdaOeN | devSdaOut) & (farSdaOeN | farSdaOut);
  modport dev (output devSclOut, devSclOeN, devSdaOut, devSdaOeN, input scl, sda);
  modport far (output farSclOut, farSclOeN, farSdaOut, farSdaOeN, input scl, sda);
endinterface : two_wire_if
`default_nettype wire

/* File: logic/two_wire_pkg.sv */
// Shared constants of the two-wire port: register map, fields, rates, states.
// Assumes a single 100 MHz clock domain on both ends.
package two_wire_pkg;
  // Register bus
  localparam int REG_ADDR_W = 2;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_DATA = 2'h1;
  localparam logic [1:0] REG_ADDR = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  // Control fields
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_ACK = 3;
  localparam int CTRL_START = 4;
  localparam int CTRL_STOP = 5;
  localparam int CTRL_EVENT = 6;
  localparam int CTRL_EN = 7;
  // Status fields
  localparam int STAT_MASTER = 0;
  localparam int STAT_TX = 1;
  localparam int STAT_ACKSEEN = 2;
  localparam int STAT_LOST = 3;
  localparam int STAT_GC = 4;
  localparam int STAT_FREE = 5;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  // Addresses
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [6:0] FAR_ADDR_DEFAULT = 7'h2A;
  // Clock rate: prescaler per code, four phase ticks per SCL period
  localparam logic [2:0] RATE_TIMER = 3'h7;
  localparam logic [9:0] PRESCALE [0:6] = '{10'h100, 10'h0E0, 10'h0C0, 10'h0A0, 10'h3C0, 10'h078, 10'h03C};
  localparam int QUARTER_SHIFT = 2;
  localparam int TIMER1_DIV = 8;
  localparam logic [1:0] OVF_PER_QUARTER = 2'(TIMER1_DIV / 4);
  // Bit counter: 0..7 data, 8 acknowledge
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  typedef enum logic [2:0] {IDLE, M_START, M_BIT, M_HOLD, M_STOP, S_BIT, S_HOLD} state_t;
  typedef enum logic [0:0] {F_IDLE, F_BIT} far_state_t;
endpackage : two_wire_pkg

/* File: logic/two_wire_port.sv */
// Two-wire master/slave port with register access and open-drain pins.
// Assumes software obeys the event flag and a timer overflow pulse on clk.
`timescale 1ns/1ns
`default_nettype none
module two_wire_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [two_wire_pkg::REG_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic timer1Overflow,
  two_wire_if.dev bus
);
  import two_wire_pkg::*;
  logic sclMeta_r, sclSync_r, sclLast_r, sdaMeta_r, sdaSync_r, sdaLast_r;
  logic sclRise, sclFall, startSeen, stopSeen, tick, match, gcMatch, driveBit;
  logic [9:0] quarter, divCnt_r, divCnt_nxt;
  logic [1:0] ovfCnt_r, ovfCnt_nxt, phase_r, phase_nxt;
  state_t state_r, state_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shift_r, shift_nxt, ownAddr_r, ownAddr_nxt, rdata_r, rdata_nxt;
  logic [2:0] rate_r, rate_nxt;
  logic ackBit_r, ackBit_nxt, en_r, en_nxt, start_r, start_nxt, stop_r, stop_nxt, event_r, event_nxt;
  logic isMaster_r, isMaster_nxt, isTx_r, isTx_nxt, first_r, first_nxt, ackSeen_r, ackSeen_nxt;
  logic lost_r, lost_nxt, gcHit_r, gcHit_nxt, free_r, free_nxt, sclOeN_r, sclOeN_nxt, sdaOeN_r, sdaOeN_nxt;

  // Two-stage synchronisers plus edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {sclMeta_r, sclSync_r, sclLast_r, sdaMeta_r, sdaSync_r, sdaLast_r} <= 6'h3F;
    end else begin
      {sclMeta_r, sclSync_r, sclLast_r} <= {bus.scl, sclMeta_r, sclSync_r};
      {sdaMeta_r, sdaSync_r, sdaLast_r} <= {bus.sda, sdaMeta_r, sdaSync_r};
    end
  end
  assign sclRise = sclSync_r & ~sclLast_r;
  assign sclFall = ~sclSync_r & sclLast_r;
  assign startSeen = sclSync_r & sclLast_r & sdaLast_r & ~sdaSync_r;
  assign stopSeen = sclSync_r & sclLast_r & ~sdaLast_r & sdaSync_r;
  assign match = shift_r[7:1] == ownAddr_r[7:1];
  assign gcMatch = ownAddr_r[0] && shift_r[7:1] == GENERAL_CALL_ADDR;
  // Value for SDA in a master bit: data when sending, ack choice when receiving
  assign driveBit = (bitCnt_r <= LAST_DATA_BIT) ? ((isTx_r | first_r) ? shift_r[7] : 1'b1)
                                                : ((isTx_r | first_r) ? 1'b1 : ~ackBit_r);

  // Phase tick: four per SCL period
  always_comb begin
    quarter = (rate_r == RATE_TIMER) ? 10'h000 : (PRESCALE[rate_r] >> QUARTER_SHIFT);
    tick = 1'b0;
    divCnt_nxt = divCnt_r + 10'h001;
    ovfCnt_nxt = ovfCnt_r;
    if (rate_r == RATE_TIMER) begin
      divCnt_nxt = 10'h000;
      if (timer1Overflow) begin
        if (ovfCnt_r == OVF_PER_QUARTER - 2'h1) begin
          tick = 1'b1;
          ovfCnt_nxt = 2'h0;
        end else begin
          ovfCnt_nxt = ovfCnt_r + 2'h1;
        end
      end
    end else if (divCnt_r >= quarter - 10'h001) begin
      tick = 1'b1;
      divCnt_nxt = 10'h000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_r <= 10'h000;
      ovfCnt_r <= 2'h0;
    end else begin
      divCnt_r <= divCnt_nxt;
      ovfCnt_r <= ovfCnt_nxt;
    end
  end

  // Registers, bus engine and framing
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    ownAddr_nxt = ownAddr_r;
    rate_nxt = rate_r;
    ackBit_nxt = ackBit_r;
    en_nxt = en_r;
    start_nxt = start_r;
    stop_nxt = stop_r;
    event_nxt = event_r;
    isMaster_nxt = isMaster_r;
    isTx_nxt = isTx_r;
    first_nxt = first_r;
    ackSeen_nxt = ackSeen_r;
    lost_nxt = lost_r;
    gcHit_nxt = gcHit_r;
    sclOeN_nxt = sclOeN_r;
    sdaOeN_nxt = sdaOeN_r;
    free_nxt = stopSeen ? 1'b1 : (startSeen ? 1'b0 : free_r);
    rdata_nxt = 8'h00;
    // Software side; hardware event setting below overrides the clear
    if (wr) begin
      if (addr == REG_CTRL) begin
        rate_nxt = wdata[CTRL_RATE_LSB +: 3];
        ackBit_nxt = wdata[CTRL_ACK];
        en_nxt = wdata[CTRL_EN];
        start_nxt = start_r | wdata[CTRL_START];
        stop_nxt = stop_r | wdata[CTRL_STOP];
        event_nxt = event_r & wdata[CTRL_EVENT];
      end else if (addr == REG_DATA) begin
        shift_nxt = wdata;
      end else if (addr == REG_ADDR) begin
        ownAddr_nxt = wdata;
      end
    end
    if (rd) begin
      if (addr == REG_CTRL) begin
        rdata_nxt = {en_r, event_r, stop_r, start_r, ackBit_r, rate_r};
      end else if (addr == REG_DATA) begin
        rdata_nxt = shift_r;
      end else if (addr == REG_ADDR) begin
        rdata_nxt = ownAddr_r;
      end else begin
        rdata_nxt = {2'h0, free_r, gcHit_r, lost_r, ackSeen_r, isTx_r, isMaster_r};
      end
    end
    if (!en_r) begin
      state_nxt = IDLE;
      sclOeN_nxt = 1'b1;
      sdaOeN_nxt = 1'b1;
      isMaster_nxt = 1'b0;
    end else begin
      case (state_r)
        IDLE: begin
          sclOeN_nxt = 1'b1;
          sdaOeN_nxt = 1'b1;
          if (start_r && free_r && !startSeen) begin
            state_nxt = M_START;
            phase_nxt = 2'h0;
            isMaster_nxt = 1'b1;
            lost_nxt = 1'b0;
          end else if (startSeen) begin
            state_nxt = S_BIT;
            bitCnt_nxt = 4'hF; // Start's own clock fall wraps this to bit 0
            first_nxt = 1'b1;
            isTx_nxt = 1'b0;
            gcHit_nxt = 1'b0;
          end
        end
        M_START: begin
          if (tick) begin
            phase_nxt = phase_r + 2'h1;
            case (phase_r)
              2'h0: sdaOeN_nxt = 1'b1;
              2'h1: sclOeN_nxt = 1'b1;
              2'h2: begin
                if (sclSync_r) begin
                  sdaOeN_nxt = 1'b0;
                end else begin
                  phase_nxt = phase_r;
                end
              end
              default: begin
                sclOeN_nxt = 1'b0;
                state_nxt = M_BIT;
                bitCnt_nxt = 4'h0;
                first_nxt = 1'b1;
                start_nxt = 1'b0;
              end
            endcase
          end
        end
        M_BIT: begin
          if (tick) begin
            phase_nxt = phase_r + 2'h1;
            case (phase_r)
              2'h0: sdaOeN_nxt = driveBit;
              2'h1: sclOeN_nxt = 1'b1;
              2'h2: begin
                if (!sclSync_r) begin
                  phase_nxt = phase_r;
                end else if (bitCnt_r == ACK_BIT) begin
                  ackSeen_nxt = ~sdaSync_r;
                end else if ((isTx_r | first_r) && sdaOeN_r && !sdaSync_r) begin
                  state_nxt = IDLE;
                  sclOeN_nxt = 1'b1;
                  sdaOeN_nxt = 1'b1;
                  isMaster_nxt = 1'b0;
                  lost_nxt = 1'b1;
                  event_nxt = 1'b1;
                end else begin
                  shift_nxt = {shift_r[6:0], sdaSync_r};
                end
              end
              default: begin
                sclOeN_nxt = 1'b0;
                if (bitCnt_r == ACK_BIT) begin
                  state_nxt = M_HOLD;
                  event_nxt = 1'b1;
                  bitCnt_nxt = 4'h0;
                  if (first_r) begin
                    isTx_nxt = ~shift_r[0];
                    first_nxt = 1'b0;
                  end
                end else begin
                  bitCnt_nxt = bitCnt_r + 4'h1;
                end
              end
            endcase
          end
        end
        M_HOLD: begin
          sclOeN_nxt = 1'b0;
          phase_nxt = 2'h0;
          if (!event_r) begin
            state_nxt = stop_r ? M_STOP : (start_r ? M_START : M_BIT);
          end
        end
        M_STOP: begin
          if (tick) begin
            phase_nxt = phase_r + 2'h1;
            case (phase_r)
              2'h0: sdaOeN_nxt = 1'b0;
              2'h1: sclOeN_nxt = 1'b1;
              default: begin
                if (sclSync_r) begin
                  sdaOeN_nxt = 1'b1;
                  state_nxt = IDLE;
                  stop_nxt = 1'b0;
                  isMaster_nxt = 1'b0;
                end else begin
                  phase_nxt = phase_r;
                end
              end
            endcase
          end
        end
        S_BIT: begin
          if (stopSeen) begin
            state_nxt = IDLE;
            sdaOeN_nxt = 1'b1;
          end else if (startSeen) begin
            bitCnt_nxt = 4'hF;
            first_nxt = 1'b1;
            isTx_nxt = 1'b0;
            sdaOeN_nxt = 1'b1;
          end else if (sclRise) begin
            if (bitCnt_r == ACK_BIT) begin
              ackSeen_nxt = ~sdaSync_r;
            end else begin
              shift_nxt = {shift_r[6:0], sdaSync_r};
            end
          end else if (sclFall) begin
            if (bitCnt_r == LAST_DATA_BIT) begin
              bitCnt_nxt = ACK_BIT;
              if (first_r) begin
                if (match || gcMatch) begin
                  sdaOeN_nxt = 1'b0;
                  gcHit_nxt = gcMatch & ~match;
                end else begin
                  state_nxt = IDLE;
                end
              end else begin
                sdaOeN_nxt = isTx_r ? 1'b1 : ~ackBit_r;
              end
            end else if (bitCnt_r == ACK_BIT) begin
              sdaOeN_nxt = 1'b1;
              sclOeN_nxt = 1'b0;
              event_nxt = 1'b1;
              state_nxt = S_HOLD;
              bitCnt_nxt = 4'h0;
              if (first_r) begin
                isTx_nxt = shift_r[0];
                first_nxt = 1'b0;
              end
            end else begin
              bitCnt_nxt = bitCnt_r + 4'h1;
              sdaOeN_nxt = isTx_r ? shift_r[7] : 1'b1;
            end
          end
        end
        default: begin
          sclOeN_nxt = 1'b0;
          if (stopSeen) begin
            state_nxt = IDLE;
            sclOeN_nxt = 1'b1;
          end else if (!event_r) begin
            state_nxt = S_BIT;
            sclOeN_nxt = 1'b1;
            sdaOeN_nxt = isTx_r ? shift_r[7] : 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= IDLE;
      phase_r <= 2'h0;
      bitCnt_r <= 4'h0;
      shift_r <= DATA_RESET;
      ownAddr_r <= ADDR_RESET;
      {en_r, event_r, stop_r, start_r, ackBit_r, rate_r} <= CTRL_RESET;
      {isMaster_r, isTx_r, first_r, ackSeen_r, lost_r, gcHit_r} <= 6'h00;
      free_r <= 1'b1;
      sclOeN_r <= 1'b1;
      sdaOeN_r <= 1'b1;
      rdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      ownAddr_r <= ownAddr_nxt;
      {en_r, event_r, stop_r, start_r, ackBit_r, rate_r} <= {en_nxt, event_nxt, stop_nxt, start_nxt, ackBit_nxt, rate_nxt};
      {isMaster_r, isTx_r, first_r, ackSeen_r, lost_r, gcHit_r} <=
        {isMaster_nxt, isTx_nxt, first_nxt, ackSeen_nxt, lost_nxt, gcHit_nxt};
      free_r <= free_nxt;
      sclOeN_r <= sclOeN_nxt;
      sdaOeN_r <= sdaOeN_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign bus.devSclOut = 1'b0; // Open drain: only ever pulls low
  assign bus.devSdaOut = 1'b0;
  assign bus.devSclOeN = sclOeN_r;
  assign bus.devSdaOeN = sdaOeN_r;
endmodule : two_wire_port
`default_nettype wire

/* File: tb/tb.sv */
// Bench joining the port to the far slave, and a second port to bench-driven pins.
// Assumes the design package, carrier and both end modules.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import two_wire_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] addrA [2];
  logic [7:0] wdA [2];
  logic wrA [2];
  logic rdA [2];
  logic [7:0] rdtA [2];
  logic ovf = 1'b0;
  logic [2:0] ovfCnt = 3'h0;
  int strobes = 0;
  logic [7:0] txByte = 8'h00;
  logic [7:0] rxByte;
  logic rxStrobe;
  logic addressed;
  int failures = 0;
  int checked = 0;
  two_wire_if wa ();
  two_wire_if wb ();
  two_wire_port i_two_wire_port (.clk(clk), .rstn(rstn), .addr(addrA[0]), .wdata(wdA[0]), .wr(wrA[0]),
    .rd(rdA[0]), .rdata(rdtA[0]), .timer1Overflow(ovf), .bus(wa));
  two_wire_port i_two_wire_port_b (.clk(clk), .rstn(rstn), .addr(addrA[1]), .wdata(wdA[1]), .wr(wrA[1]),
    .rd(rdA[1]), .rdata(rdtA[1]), .timer1Overflow(ovf), .bus(wb));
  far_slave i_far_slave (.clk(clk), .rstn(rstn), .bus(wa), .txByte(txByte), .rxByte(rxByte),
    .rxStrobe(rxStrobe), .addressed(addressed));
  two_wire_checker i_two_wire_checker (.clk(clk), .rstn(rstn), .scl(wa.scl), .sda(wa.sda),
    .devSclOeN(wa.devSclOeN), .devSdaOeN(wa.devSdaOeN), .farSdaOeN(wa.farSdaOeN));
  always #5 clk = ~clk;
  // Timer overflow pulse every fifth clock, the shortest reload allowed
  always @(posedge clk) begin
    ovfCnt <= (ovfCnt == 3'h4) ? 3'h0 : ovfCnt + 3'h1;
    ovf <= (ovfCnt == 3'h4);
  end
  // Count far slave byte strobes
  always @(posedge clk) if (rxStrobe === 1'b1) strobes <= strobes + 1;
  task automatic print_verdict();
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wreg(input int p, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addrA[p] <= a;
    wdA[p] <= d;
    wrA[p] <= 1'b1;
    @(posedge clk);
    wrA[p] <= 1'b0;
  endtask : wreg
  task automatic rreg(input int p, input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addrA[p] <= a;
    rdA[p] <= 1'b1;
    @(posedge clk);
    rdA[p] <= 1'b0;
    #1 d = rdtA[p];
  endtask : rreg
  task automatic waitEvent(input int p);
    logic [7:0] v;
    v = 8'h00;
    for (int n = 0; n < 3000 && v[CTRL_EVENT] !== 1'b1; n++) rreg(p, REG_CTRL, v);
    check("event", v & 8'h40, 8'h40);
  endtask : waitEvent
  task automatic stopMaster(input logic [2:0] rate);
    logic [7:0] v;
    v = 8'h00;
    wreg(0, REG_CTRL, {5'h14, rate});
    for (int n = 0; n < 3000 && v[STAT_FREE] !== 1'b1; n++) rreg(0, REG_STAT, v);
    check("bus free", v & 8'h21, 8'h20);
    check("far released", {7'h00, addressed}, 8'h00);
  endtask : stopMaster
  task automatic resetValues();
    logic [7:0] v;
    for (int a = 0; a < 3; a++) begin
      rreg(0, 2'(a), v);
      check("reset value", v, 8'h00);
    end
    rreg(0, REG_STAT, v);
    check("reset status", v, 8'h20);
  endtask : resetValues
  task automatic masterWrite(input logic [2:0] rate, input int expPer);
    time t0;
    int per;
    int s0;
    logic [7:0] v;
    s0 = strobes;
    wreg(0, REG_DATA, 8'h54);
    wreg(0, REG_CTRL, {5'h12, rate});
    @(posedge wa.scl);
    t0 = $time;
    @(posedge wa.scl);
    per = int'(($time - t0) / 10);
    check("scl period", 8'((per - expPer) / 5), 8'h00);
    waitEvent(0);
    rreg(0, REG_STAT, v);
    check("master tx status", v & 8'h07, 8'h07);
    check("far addressed", {7'h00, addressed}, 8'h01);
    wreg(0, REG_DATA, 8'hA5);
    wreg(0, REG_CTRL, {5'h10, rate});
    waitEvent(0);
    check("far byte", rxByte, 8'hA5);
    check("far strobe", 8'(strobes - s0), 8'h01);
    stopMaster(rate);
  endtask : masterWrite
  task automatic masterRead();
    logic [7:0] v;
    txByte <= 8'h3C;
    wreg(0, REG_DATA, 8'h55);
    wreg(0, REG_CTRL, 8'h96);
    waitEvent(0);
    wreg(0, REG_CTRL, 8'h86);
    waitEvent(0);
    rreg(0, REG_DATA, v);
    check("master rx byte", v, 8'h3C);
    rreg(0, REG_STAT, v);
    check("master rx status", v & 8'h03, 8'h01);
    stopMaster(3'h6);
  endtask : masterRead
  task automatic bb(input logic c, input logic d);
    wb.farSclOeN <= c;
    wb.farSdaOeN <= d;
    repeat (30) @(posedge clk);
  endtask : bb
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bb(1'b0, b[i]);
      bb(1'b1, b[i]);
      bb(1'b0, b[i]);
    end
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
    ack = !wb.sda;
    bb(1'b0, 1'b1);
  endtask : sendByte
  task automatic slaveFrame(input logic [7:0] a, input logic expAck, input logic ackBit, input logic [7:0] d);
    logic ack;
    logic [7:0] v;
    bb(1'b1, 1'b1);
    bb(1'b1, 1'b0);
    bb(1'b0, 1'b0);
    sendByte(a, ack);
    check("slave address ack", {7'h00, ack}, {7'h00, expAck});
    if (expAck) begin
      waitEvent(1);
      check("slave stretch", {7'h00, wb.devSclOeN}, 8'h00);
      if (a[0]) wreg(1, REG_DATA, d);
      wreg(1, REG_CTRL, {4'h8, ackBit, 3'h6});
      if (a[0]) begin
        // Bench clocks the byte in, then answers with a release
        for (int i = 7; i >= -1; i--) begin
          bb(1'b0, 1'b1);
          bb(1'b1, 1'b1);
          if (i >= 0) v[i] = wb.sda;
          bb(1'b0, 1'b1);
        end
        check("slave tx byte", v, d);
      end else begin
        sendByte(d, ack);
        check("slave data ack", {7'h00, ack}, {7'h00, ackBit});
      end
      waitEvent(1);
      if (a[0]) begin
        rreg(1, REG_STAT, v);
        check("slave tx status", v & 8'h06, 8'h02);
      end
      rreg(1, REG_DATA, v);
      check("slave data", v, d);
      wreg(1, REG_CTRL, 8'h8E);
    end
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    rreg(1, REG_STAT, v);
    check("slave idle", v & 8'h21, 8'h20);
  endtask : slaveFrame
  task automatic slaveTests();
    wreg(1, REG_ADDR, 8'h63);
    wreg(1, REG_CTRL, 8'h8E);
    slaveFrame(8'h62, 1'b1, 1'b1, 8'hC3);
    slaveFrame(8'h62, 1'b1, 1'b0, 8'h3C);
    slaveFrame(8'h00, 1'b1, 1'b1, 8'h81);
    slaveFrame(8'h63, 1'b1, 1'b1, 8'h96);
    wreg(1, REG_ADDR, 8'h62);
    slaveFrame(8'h00, 1'b0, 1'b1, 8'h00);
    slaveFrame(8'h24, 1'b0, 1'b1, 8'h00);
  endtask : slaveTests
  task automatic arbitration();
    logic [7:0] v;
    wreg(1, REG_DATA, 8'hA0);
    wreg(1, REG_CTRL, 8'h96);
    @(negedge wb.scl);
    wb.farSdaOeN <= 1'b0;
    waitEvent(1);
    rreg(1, REG_STAT, v);
    check("lost", v & 8'h09, 8'h08);
    check("loser released", {6'h00, wb.devSclOeN, wb.devSdaOeN}, 8'h03);
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
  endtask : arbitration
  // Main sequence
  initial begin
    for (int p = 0; p < 2; p++) begin
      addrA[p] = 2'h0;
      wdA[p] = 8'h00;
      wrA[p] = 1'b0;
      rdA[p] = 1'b0;
    end
    wb.farSclOut = 1'b0;
    wb.farSdaOut = 1'b0;
    wb.farSclOeN = 1'b1;
    wb.farSdaOeN = 1'b1;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    resetValues();
    masterWrite(3'h6, 60);
    masterWrite(3'h7, 40);
    masterRead();
    slaveTests();
    arbitration();
    print_verdict();
  end
  // Watchdog
  initial begin
    #800000;
    failures++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire

/* File: tb/two_wire_checker.sv */
// Checker of the wire between the port and the far slave.
// Assumes one clock and the carrier's signals as plain inputs.
`timescale 1ns/1ns
`default_nettype none
module two_wire_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic devSclOeN,
  input wire logic devSdaOeN,
  input wire logic farSdaOeN
);
  logic sclPrev_r;
  logic sdaPrev_r;
  logic sclRise;
  logic startHit;
  logic [3:0] riseCnt_r;
  logic [3:0] riseCnt_nxt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence startSeq;
    scl && $fell(sda);
  endsequence
  sequence stopSeq;
    scl && $rose(sda);
  endsequence
  // Clock rises since the last start
  always_comb begin
    sclRise = scl && !sclPrev_r;
    startHit = scl && sclPrev_r && sdaPrev_r && !sda;
    riseCnt_nxt = riseCnt_r;
    if (startHit) riseCnt_nxt = 4'h0;
    else if (sclRise && riseCnt_r != 4'hF) riseCnt_nxt = riseCnt_r + 4'h1;
  end
  // Edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      riseCnt_r <= 4'hF;
    end else begin
      sclPrev_r <= scl;
      sdaPrev_r <= sda;
      riseCnt_r <= riseCnt_nxt;
    end
  end
  AST_PINS_FREE_AT_RESET: assert property ($rose(rstn) |-> devSclOeN && devSdaOeN)
    else $error("pins driven after reset");
  AST_START_THEN_LOW: assert property (startSeq |-> ##[1:100] !scl)
    else $error("no clock low after start");
  AST_STOP_RELEASES: assert property (stopSeq |-> (devSclOeN && devSdaOeN) [*8])
    else $error("pins held after stop");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");
  AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low too short");
  AST_FAR_DATA_LOW: assert property ($changed(farSdaOeN) |-> !scl)
    else $error("far data moved with clock high");
  AST_ADDR_ACKED: assert property (sclRise && riseCnt_r == 4'h8 |-> !sda)
    else $error("address not acknowledged");
  AST_DEV_DATA_FRAMING: assert property ($changed(devSdaOeN) && scl |-> $fell(sda) || $rose(sda))
    else $error("data moved with clock high");
endmodule : two_wire_checker
`default_nettype wire
